// ---- rtl/mlpo_regs.svh ----
// Register offsets, field positions and reset values of the pin override.
`ifndef MLPO_REGS_SVH
`define MLPO_REGS_SVH

`define MLPO_DRIVE_OFS 8'h0c
`define MLPO_SWAP_OFS 8'h10
`define MLPO_DRIVE_RST 32'h00000002
`define MLPO_SWAP_RST 32'h00000000

`define MLPO_IRQEN_BIT 0
`define MLPO_DIRECT_BIT 1
`define MLPO_LVL2_BIT 2
`define MLPO_LVL1_BIT 3
`define MLPO_NSEL_LSB 4
`define MLPO_PSEL_LSB 6
`define MLPO_SWAP_BIT 0

`define MLPO_SEL_HIZ_BIT 0
`define MLPO_SEL_LVL_BIT 1

`define MLPO_HTRANS_ACT_BIT 1
`define MLPO_ADDR_LSB_MASK 2'b00
`define MLPO_RESP_OKAY 1'b0
`define MLPO_RESP_ERROR 1'b1

`endif

// ---- rtl/mlpo_pkg.sv ----
// Types and shared helpers of the pin override block.
`include "mlpo_regs.svh"

package mlpo_pkg;

  typedef struct packed {
    logic drv;
    logic oe;
  } mlpo_pin_t;

  typedef struct packed {
    logic [1:0] psel;
    logic [1:0] nsel;
    logic direct_en;
    logic swap;
  } mlpo_ctrl_t;

  typedef enum logic [1:0] {
    MLPO_BUS_OK,
    MLPO_BUS_ERR1,
    MLPO_BUS_ERR2
  } mlpo_bus_t;

  // Control fields as they stand after reset.
  function automatic mlpo_ctrl_t rst_ctrl();
    mlpo_ctrl_t c;
    logic [31:0] dr;
    logic [31:0] sr;
    dr = `MLPO_DRIVE_RST;
    sr = `MLPO_SWAP_RST;
    c.psel = dr[`MLPO_PSEL_LSB +: 2];
    c.nsel = dr[`MLPO_NSEL_LSB +: 2];
    c.direct_en = dr[`MLPO_DIRECT_BIT];
    c.swap = sr[`MLPO_SWAP_BIT];
    return c;
  endfunction

  // X1 floats the pin, 00 drives low, 10 drives high.
  function automatic mlpo_pin_t sel_decode(input logic [1:0] sel);
    mlpo_pin_t p;
    p.oe = ~sel[`MLPO_SEL_HIZ_BIT];
    p.drv = sel[`MLPO_SEL_LVL_BIT] & ~sel[`MLPO_SEL_HIZ_BIT];
    return p;
  endfunction

endpackage

// ---- rtl/mlpo_sync.sv ----
// Two flip-flop synchroniser for level signals entering a clock domain.
`timescale 1ns/1ns

module mlpo_sync #(
  parameter int W = 1
) (
  input wire logic clk_i, // Destination clock.
  input wire logic [W-1:0] d_i, // Asynchronous level.
  output logic [W-1:0] q_o // Synchronised level.
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  if (W < 1) begin : g_bad_width
    $error("mlpo_sync width must be at least one");
  end

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign q_o = sync_q;

endmodule

// ---- rtl/mlpo_link.sv ----
// Link-clock side: control capture and drive pin multiplexing.
`timescale 1ns/1ns
`include "mlpo_regs.svh"

module mlpo_link (
  input wire logic link_clk_i, // Link clock.
  input wire logic sys_rst_i, // System reset, asynchronous here.
  input wire logic req_i, // Toggle from system side.
  input wire mlpo_pkg::mlpo_ctrl_t ctrl_i, // Held while toggle pending.
  input wire mlpo_pkg::mlpo_pin_t proto_pos_i, // Protocol drive, pos.
  input wire mlpo_pkg::mlpo_pin_t proto_neg_i, // Protocol drive, neg.
  output logic ack_o, // Toggle back to system side.
  output mlpo_pkg::mlpo_pin_t pos_o, // Positive pin drive.
  output mlpo_pkg::mlpo_pin_t neg_o // Negative pin drive.
);

  logic rst_l;
  logic req_s;
  logic seen_q;
  logic seen_d;
  mlpo_pkg::mlpo_ctrl_t ctrl_q;
  mlpo_pkg::mlpo_ctrl_t ctrl_d;
  mlpo_pkg::mlpo_pin_t pos_q;
  mlpo_pkg::mlpo_pin_t pos_d;
  mlpo_pkg::mlpo_pin_t neg_q;
  mlpo_pkg::mlpo_pin_t neg_d;
  logic [1:0] pos_sel;
  logic [1:0] neg_sel;

  // Pin drive after reset, worked out once from the control reset value.
  localparam mlpo_pkg::mlpo_ctrl_t RST_CTRL = mlpo_pkg::rst_ctrl();
  localparam mlpo_pkg::mlpo_pin_t RST_POS =
    mlpo_pkg::sel_decode(RST_CTRL.psel);
  localparam mlpo_pkg::mlpo_pin_t RST_NEG =
    mlpo_pkg::sel_decode(RST_CTRL.nsel);

  mlpo_sync #(.W(1)) u_rst_sync (
    .clk_i(link_clk_i),
    .d_i(sys_rst_i),
    .q_o(rst_l)
  );

  mlpo_sync #(.W(1)) u_req_sync (
    .clk_i(link_clk_i),
    .d_i(req_i),
    .q_o(req_s)
  );

  always_comb begin
    seen_d = req_s;
    ctrl_d = ctrl_q;
    if (req_s != seen_q) begin
      ctrl_d = ctrl_i;
    end
    pos_sel = ctrl_q.swap ? ctrl_q.nsel : ctrl_q.psel;
    neg_sel = ctrl_q.swap ? ctrl_q.psel : ctrl_q.nsel;
    if (ctrl_q.direct_en) begin
      pos_d = mlpo_pkg::sel_decode(pos_sel);
      neg_d = mlpo_pkg::sel_decode(neg_sel);
    end else begin
      // Protocol engine supplies power, clock and PWM data here.
      pos_d = proto_pos_i;
      neg_d = proto_neg_i;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      seen_q <= 1'b0;
      ctrl_q <= RST_CTRL;
      pos_q <= RST_POS;
      neg_q <= RST_NEG;
    end else begin
      seen_q <= seen_d;
      ctrl_q <= ctrl_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign ack_o = seen_q;
  assign pos_o = pos_q;
  assign neg_o = neg_q;

  default clocking cb_link @(posedge link_clk_i);
  endclocking
  default disable iff (rst_l);

  sequence s_new_req;
    req_s != seen_q;
  endsequence

  property p_capture;
    s_new_req |=> (ctrl_q == $past(ctrl_i)) && (ack_o != $past(ack_o));
  endproperty
  a_capture: assert property (p_capture)
    else $error("new control word not captured with acknowledge");

  property p_pos_high;
    ctrl_q.direct_en && !ctrl_q.swap && ctrl_q.psel == 2'b10
      |=> pos_q.oe && pos_q.drv;
  endproperty
  a_pos_high: assert property (p_pos_high)
    else $error("positive pin not driven high under select 10");

  property p_neg_hiz;
    ctrl_q.direct_en && !ctrl_q.swap && ctrl_q.nsel[0] |=> !neg_q.oe;
  endproperty
  a_neg_hiz: assert property (p_neg_hiz)
    else $error("negative pin not floating under select X1");

  property p_swap_low;
    ctrl_q.direct_en && ctrl_q.swap && ctrl_q.nsel == 2'b00
      |=> pos_q.oe && !pos_q.drv;
  endproperty
  a_swap_low: assert property (p_swap_low)
    else $error("swapped negative select did not drive positive low");

  property p_proto;
    !ctrl_q.direct_en
      |=> pos_q == $past(proto_pos_i) && neg_q == $past(proto_neg_i);
  endproperty
  a_proto: assert property (p_proto)
    else $error("pins not following protocol drive");

endmodule

// ---- rtl/mlpo_top.sv ----
// Drive pin override register with AHB slave and link-clock pin logic.
`timescale 1ns/1ns
`include "mlpo_regs.svh"

module mlpo_top (
  input wire logic clk_i, // System clock, 25 MHz.
  input wire logic sys_rst_i, // Synchronous reset, active high.
  input wire logic link_clk_i, // Link clock for pin logic.
  input wire logic hsel_i, // AHB slave select.
  input wire logic [31:0] haddr_i, // AHB address.
  input wire logic [1:0] htrans_i, // AHB transfer type.
  input wire logic hwrite_i, // AHB write.
  input wire logic [31:0] hwdata_i, // AHB write data.
  input wire logic hready_i, // AHB bus ready.
  output logic [31:0] hrdata_o, // AHB read data.
  output logic hreadyout_o, // AHB slave ready.
  output logic hresp_o, // AHB response.
  input wire logic modem_status_flag_i, // Modem status flag.
  output logic irq_o, // Modem interrupt.
  input wire mlpo_pkg::mlpo_pin_t proto_pos_i, // Engine drive, link clk.
  input wire mlpo_pkg::mlpo_pin_t proto_neg_i, // Engine drive, link clk.
  input wire logic drive_pin_positive_i, // Positive pin level.
  input wire logic drive_pin_negative_i, // Negative pin level.
  output mlpo_pkg::mlpo_pin_t drive_pin_positive_o, // Positive drive.
  output mlpo_pkg::mlpo_pin_t drive_pin_negative_o // Negative drive.
);

  mlpo_pkg::mlpo_ctrl_t ctrl_q;
  mlpo_pkg::mlpo_ctrl_t ctrl_d;
  logic irq_en_q;
  logic irq_en_d;
  logic irq_q;
  logic irq_d;

  logic wr_pend_q;
  logic wr_pend_d;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_addr_d;
  logic wr_lane0_q;
  logic wr_lane0_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  mlpo_pkg::mlpo_bus_t bus_q;
  mlpo_pkg::mlpo_bus_t bus_d;
  logic hreadyout_q;
  logic hreadyout_d;
  logic hresp_q;
  logic hresp_d;
  logic acc;
  logic mapped;

  mlpo_pkg::mlpo_ctrl_t shadow_q;
  mlpo_pkg::mlpo_ctrl_t shadow_d;
  logic req_q;
  logic req_d;
  logic ack_l;
  logic ack_s;
  logic [1:0] lvl_s;

  localparam logic [31:0] DRIVE_RST = `MLPO_DRIVE_RST;

  function automatic logic is_mapped(input logic [7:0] a);
    logic m;
    m = 1'b0;
    if (a == `MLPO_DRIVE_OFS) begin
      m = 1'b1;
    end else if (a == `MLPO_SWAP_OFS) begin
      m = 1'b1;
    end
    return m;
  endfunction

  function automatic logic [31:0] read_word(
    input logic [7:0] a,
    input mlpo_pkg::mlpo_ctrl_t c,
    input logic ie,
    input logic [1:0] lvl
  );
    logic [31:0] w;
    w = '0;
    if (a == `MLPO_DRIVE_OFS) begin
      w[`MLPO_PSEL_LSB +: 2] = c.psel;
      w[`MLPO_NSEL_LSB +: 2] = c.nsel;
      w[`MLPO_DIRECT_BIT] = c.direct_en;
      w[`MLPO_IRQEN_BIT] = ie;
      w[`MLPO_LVL1_BIT] = c.swap ? lvl[0] : lvl[1];
      w[`MLPO_LVL2_BIT] = c.swap ? lvl[1] : lvl[0];
    end else if (a == `MLPO_SWAP_OFS) begin
      w[`MLPO_SWAP_BIT] = c.swap;
    end
    return w;
  endfunction

  // Pin levels: bit 1 positive, bit 0 negative.
  mlpo_sync #(.W(2)) u_lvl_sync (
    .clk_i(clk_i),
    .d_i({drive_pin_positive_i, drive_pin_negative_i}),
    .q_o(lvl_s)
  );

  mlpo_sync #(.W(1)) u_ack_sync (
    .clk_i(clk_i),
    .d_i(ack_l),
    .q_o(ack_s)
  );

  mlpo_link u_link (
    .link_clk_i(link_clk_i),
    .sys_rst_i(sys_rst_i),
    .req_i(req_q),
    .ctrl_i(shadow_q),
    .proto_pos_i(proto_pos_i),
    .proto_neg_i(proto_neg_i),
    .ack_o(ack_l),
    .pos_o(drive_pin_positive_o),
    .neg_o(drive_pin_negative_o)
  );

  // Write data phase updates the control fields.
  always_comb begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    if (wr_pend_q && wr_lane0_q) begin
      if (wr_addr_q == `MLPO_DRIVE_OFS) begin
        ctrl_d.psel = hwdata_i[`MLPO_PSEL_LSB +: 2];
        ctrl_d.nsel = hwdata_i[`MLPO_NSEL_LSB +: 2];
        ctrl_d.direct_en = hwdata_i[`MLPO_DIRECT_BIT];
        irq_en_d = hwdata_i[`MLPO_IRQEN_BIT];
      end else if (wr_addr_q == `MLPO_SWAP_OFS) begin
        ctrl_d.swap = hwdata_i[`MLPO_SWAP_BIT];
      end
    end
    irq_d = modem_status_flag_i & irq_en_q;
  end

  // Address phase; unmapped addresses get a two-cycle ERROR unless accepted in the second ERROR cycle.
  always_comb begin
    acc = hsel_i && hready_i && htrans_i[`MLPO_HTRANS_ACT_BIT];
    mapped = is_mapped(haddr_i[7:0]);
    wr_pend_d = acc && hwrite_i && mapped;
    wr_addr_d = haddr_i[7:0];
    wr_lane0_d = haddr_i[1:0] == `MLPO_ADDR_LSB_MASK;
    hrdata_d = '0;
    if (acc && !hwrite_i) begin
      // Read from next values so a read right after a write sees it.
      hrdata_d = read_word(haddr_i[7:0], ctrl_d, irq_en_d, lvl_s);
    end
    bus_d = mlpo_pkg::MLPO_BUS_OK;
    case (bus_q)
      mlpo_pkg::MLPO_BUS_OK: begin
        if (acc && !mapped) begin
          bus_d = mlpo_pkg::MLPO_BUS_ERR1;
        end
      end
      mlpo_pkg::MLPO_BUS_ERR1: begin
        bus_d = mlpo_pkg::MLPO_BUS_ERR2;
      end
      default: begin
        bus_d = mlpo_pkg::MLPO_BUS_OK;
      end
    endcase
    hreadyout_d = bus_d != mlpo_pkg::MLPO_BUS_ERR1;
    hresp_d = (bus_d == mlpo_pkg::MLPO_BUS_OK) ? `MLPO_RESP_OKAY
                                               : `MLPO_RESP_ERROR;
  end

  // Control word crosses by toggle handshake; shadow holds until acked.
  always_comb begin
    shadow_d = shadow_q;
    req_d = req_q;
    if ((req_q == ack_s) && (shadow_q != ctrl_q)) begin
      shadow_d = ctrl_q;
      req_d = ~req_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= mlpo_pkg::rst_ctrl();
      irq_en_q <= DRIVE_RST[`MLPO_IRQEN_BIT];
      irq_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      wr_lane0_q <= 1'b0;
      hrdata_q <= '0;
      bus_q <= mlpo_pkg::MLPO_BUS_OK;
      hreadyout_q <= 1'b1;
      hresp_q <= `MLPO_RESP_OKAY;
      shadow_q <= mlpo_pkg::rst_ctrl();
      req_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      wr_lane0_q <= wr_lane0_d;
      hrdata_q <= hrdata_d;
      bus_q <= bus_d;
      hreadyout_q <= hreadyout_d;
      hresp_q <= hresp_d;
      shadow_q <= shadow_d;
      req_q <= req_d;
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hreadyout_q;
  assign hresp_o = hresp_q;
  assign irq_o = irq_q;

  default clocking cb_sys @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_drive_wr;
    wr_pend_q && wr_lane0_q && wr_addr_q == `MLPO_DRIVE_OFS;
  endsequence

  sequence s_drive_rd;
    hsel_i && hready_i && htrans_i[`MLPO_HTRANS_ACT_BIT] && !hwrite_i
      && haddr_i[7:0] == `MLPO_DRIVE_OFS;
  endsequence

  property p_irq_on;
    modem_status_flag_i && irq_en_q |=> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled status flag did not raise interrupt");

  property p_irq_off;
    !irq_en_q ##1 !irq_en_q |-> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt raised while disabled");

  property p_reset_val;
    @(posedge clk_i) disable iff (1'b0)
    sys_rst_i |=> ctrl_q == mlpo_pkg::rst_ctrl() && !irq_en_q;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("control register not at reset value");

  property p_drive_wr;
    s_drive_wr |=> ctrl_q.psel == $past(hwdata_i[`MLPO_PSEL_LSB +: 2])
      && ctrl_q.nsel == $past(hwdata_i[`MLPO_NSEL_LSB +: 2])
      && ctrl_q.direct_en == $past(hwdata_i[`MLPO_DIRECT_BIT])
      && irq_en_q == $past(hwdata_i[`MLPO_IRQEN_BIT]);
  endproperty
  a_drive_wr: assert property (p_drive_wr)
    else $error("drive register write not stored");

  property p_levels;
    s_drive_rd |=> hrdata_o[3] == $past(ctrl_d.swap ? lvl_s[0] : lvl_s[1])
      && hrdata_o[2] == $past(ctrl_d.swap ? lvl_s[1] : lvl_s[0]);
  endproperty
  a_levels: assert property (p_levels)
    else $error("pin level bits wrong for swap setting");

endmodule

// ---- bench/mlpo_lsd_model.sv ----
// Line-side device model that resolves the two drive pin wires it sees.
`timescale 1ns/1ns

module mlpo_lsd_model (
  input wire logic link_clk_i, // Link clock.
  input wire mlpo_pkg::mlpo_pin_t pos_i, // Positive pin drive.
  input wire mlpo_pkg::mlpo_pin_t neg_i, // Negative pin drive.
  output logic pos_lvl_o, // Positive wire level.
  output logic neg_lvl_o // Negative wire level.
);
  logic flip_q = 1'b0;

  // A released wire has no pull, so it shows a changing pattern instead.
  always @(posedge link_clk_i) begin
    flip_q <= ~flip_q;
  end

  // The driven wire carries power, clock and modulated data to the device.
  assign pos_lvl_o = pos_i.oe ? pos_i.drv : flip_q;
  assign neg_lvl_o = neg_i.oe ? neg_i.drv : ~flip_q;
endmodule

// ---- bench/modem_link_pin_override_test.sv ----
// Self-checking testbench of the drive pin override block.
`timescale 1ns/1ns

module modem_link_pin_override_test;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i, hwrite_i, modem_status_flag_i;
  wire logic hready_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i;
  logic hreadyout_o, hresp_o, irq_o, resp;
  mlpo_pkg::mlpo_pin_t proto_pos_i, proto_neg_i;
  mlpo_pkg::mlpo_pin_t drive_pin_positive_o, drive_pin_negative_o;
  logic drive_pin_positive_i, drive_pin_negative_i;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  int wait_n = 0;

  always #20 clk_i = ~clk_i;
  always #16 link_clk_i = ~link_clk_i;

  // Single slave on the bus, so the bus ready follows the slave ready.
  assign hready_i = hreadyout_o;

  mlpo_top dut (
    .clk_i, .sys_rst_i, .link_clk_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
    .modem_status_flag_i, .irq_o, .proto_pos_i, .proto_neg_i,
    .drive_pin_positive_i, .drive_pin_negative_i,
    .drive_pin_positive_o, .drive_pin_negative_o
  );

  mlpo_lsd_model lsd (
    .link_clk_i,
    .pos_i(drive_pin_positive_o),
    .neg_i(drive_pin_negative_o),
    .pos_lvl_o(drive_pin_positive_i),
    .neg_lvl_o(drive_pin_negative_i)
  );

  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One transfer: address phase, then data phase until the slave is ready.
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv,
                     output logic rsp);
    int k;
    @(posedge clk_i);
    #2;
    hsel_i = 1'b1;
    htrans_i = 2'b10;
    hwrite_i = wr;
    haddr_i = {24'h000000, a};
    @(posedge clk_i);
    #2;
    hsel_i = 1'b0;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    hwdata_i = wd;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 4);
    rdv = hrdata_o;
    rsp = hresp_o;
    wait_n = k;
  endtask

  // Expected pin drive {drv, oe} for a select code.
  function automatic logic [1:0] dec(input logic [1:0] s);
    return {s[1] & ~s[0], ~s[0]};
  endfunction

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    logic [1:0] ps, ns, ep, en, lv;
    logic dir, ie, sw, fl;
    hsel_i = 1'b0;
    hwrite_i = 1'b0;
    htrans_i = 2'b00;
    haddr_i = 32'h00000000;
    hwdata_i = 32'h00000000;
    modem_status_flag_i = 1'b0;
    proto_pos_i = 2'h0;
    proto_neg_i = 2'h0;
    void'($urandom(1052));
    repeat (10) @(posedge clk_i);
    #2;
    sys_rst_i = 1'b0;
    ahb(1'b0, 8'h0c, 32'h0, rd, resp);
    check("drive reset", rd, 32'h00000002);
    check("pos reset", drive_pin_positive_o, 32'h1);
    check("neg reset", drive_pin_negative_o, 32'h1);
    check("irq reset", irq_o, 32'h0);
    ahb(1'b0, 8'h10, 32'h0, rd, resp);
    check("swap reset", rd, 32'h00000000);
    ahb(1'b0, 8'h20, 32'h0, rd, resp);
    check("unmapped resp", resp, 32'h1);
    check("unmapped wait", wait_n, 32'h2);
    ahb(1'b1, 8'h20, 32'h000000f1, rd, resp);
    check("unmapped wr resp", resp, 32'h1);
    ahb(1'b0, 8'h0c, 32'h0, rd, resp);
    check("drive kept", rd, 32'h00000002);
    for (int i = 0; i < 40; i++) begin
      if (i < 16) begin
        ps = i[3:2];
        ns = i[1:0];
        dir = 1'b1;
        sw = i[0] ^ i[3];
      end else begin
        {ps, ns, dir, sw} = 6'($urandom);
      end
      ie = 1'($urandom);
      fl = 1'($urandom);
      ahb(1'b1, 8'h10, {31'h0, sw}, rd, resp);
      ahb(1'b1, 8'h0c, {24'h0, ps, ns, 2'b00, dir, ie}, rd, resp);
      check("write resp", resp, 32'h0);
      check("write wait", wait_n, 32'h1);
      @(posedge link_clk_i);
      #2;
      proto_pos_i = 2'($urandom);
      proto_neg_i = 2'($urandom);
      @(posedge clk_i);
      #2;
      modem_status_flag_i = fl;
      repeat (20) @(posedge link_clk_i);
      ep = dir ? dec(sw ? ns : ps) : proto_pos_i;
      en = dir ? dec(sw ? ps : ns) : proto_neg_i;
      check("pos pin", drive_pin_positive_o, ep);
      check("neg pin", drive_pin_negative_o, en);
      ahb(1'b0, 8'h0c, 32'h0, rd, resp);
      check("drive fields", {rd[7:4], rd[1:0]}, {ps, ns, dir, ie});
      check("irq", irq_o, fl & ie);
      // A released wire has no defined level, so only driven pairs are read.
      if (ep[0] & en[0]) begin
        lv = sw ? {en[1], ep[1]} : {ep[1], en[1]};
        check("levels", rd[3:2], lv);
      end
    end
    give_verdict();
  end
endmodule
